/* rtl/opcode_decoder_defs.vh */
`ifndef OPCODE_DECODER_DEFS_VH
`define OPCODE_DECODER_DEFS_VH
// Escape byte to the two-byte table
`define ESCAPE_BYTE 8'h0F
// Addressing method codes
`define AM_NONE 4'h0
`define AM_DIRECT 4'h1
`define AM_CTRL 4'h2
`define AM_DEBUG 4'h3
`define AM_RM 4'h4
`define AM_FLAGS 4'h5
`define AM_GREG 4'h6
`define AM_IMM 4'h7
`define AM_REL 4'h8
`define AM_MEM 4'h9
`define AM_MOFFS 4'hA
`define AM_RONLY 4'hB
`define AM_SEG 4'hC
`define AM_TEST 4'hD
`define AM_SRCSTR 4'hE
`define AM_DSTSTR 4'hF
// Operand type codes
`define OT_NONE 3'h0
`define OT_B 3'h1
`define OT_W 3'h2
`define OT_D 3'h3
`define OT_V 3'h4
`define OT_P 3'h5
`define OT_S 3'h6
`define OT_A 3'h7
// Segment selector codes for string pointers
`define SEG_ES 3'h0
`define SEG_DS 3'h3
// Index register numbers
`define REG_SI 3'h6
`define REG_DI 3'h7
// Register file selectors
`define RF_NONE 3'h0
`define RF_GEN16 3'h1
`define RF_GEN32 3'h2
`define RF_SEG 3'h3
`define RF_CTRL 3'h4
`define RF_DEBUG 3'h5
`define RF_TEST 3'h6
`define RF_GEN8 3'h7
`endif

/* rtl/operand_spec_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decoder_defs.vh"
module operand_spec_decode
(
	// Operand descriptor
	input wire [3:0] method,
	input wire [2:0] otype,
	input wire op32,
	input wire addr32,
	input wire [7:0] modrm,
	// Decoded operand
	output reg needs_modrm,
	output reg [3:0] size_bytes,
	output reg [2:0] reg_file,
	output reg [2:0] reg_num,
	output reg is_mem,
	output reg [2:0] seg_sel,
	output reg [2:0] imm_bytes,
	output reg rel_signed,
	output reg bad_form
);
	always @*
	begin
		needs_modrm = 1'b0;
		reg_file = `RF_NONE;
		reg_num = modrm[5:3];
		is_mem = 1'b0;
		seg_sel = `SEG_DS;
		imm_bytes = 3'h0;
		rel_signed = 1'b0;
		bad_form = 1'b0;
		case (otype)
			`OT_B: size_bytes = 4'h1;
			`OT_W: size_bytes = 4'h2;
			`OT_D: size_bytes = 4'h4;
			`OT_V: size_bytes = op32 ? 4'h4 : 4'h2;
			`OT_P: size_bytes = op32 ? 4'h6 : 4'h4;
			`OT_S: size_bytes = 4'h6;
			`OT_A: size_bytes = op32 ? 4'h8 : 4'h4;
			default: size_bytes = 4'h0;
		endcase
		case (method)
			`AM_DIRECT:
			begin
				is_mem = 1'b1;
				imm_bytes = size_bytes[2:0];
			end
			`AM_CTRL:
			begin
				needs_modrm = 1'b1;
				reg_file = `RF_CTRL;
			end
			`AM_DEBUG:
			begin
				needs_modrm = 1'b1;
				reg_file = `RF_DEBUG;
			end
			`AM_TEST:
			begin
				needs_modrm = 1'b1;
				reg_file = `RF_TEST;
			end
			`AM_GREG:
			begin
				needs_modrm = 1'b1;
				reg_file = (size_bytes == 4'h1) ? `RF_GEN8 :
					(size_bytes == 4'h4) ? `RF_GEN32 : `RF_GEN16;
			end
			`AM_SEG:
			begin
				needs_modrm = 1'b1;
				reg_file = `RF_SEG;
			end
			`AM_MOFFS:
			begin
				is_mem = 1'b1;
				imm_bytes = addr32 ? 3'h4 : 3'h2;
			end
			`AM_SRCSTR:
			begin
				is_mem = 1'b1;
				seg_sel = `SEG_DS;
				reg_num = `REG_SI;
			end
			`AM_DSTSTR:
			begin
				is_mem = 1'b1;
				seg_sel = `SEG_ES;
				reg_num = `REG_DI;
			end
			`AM_REL:
			begin
				rel_signed = 1'b1;
				imm_bytes = size_bytes[2:0];
			end
			`AM_MEM:
			begin
				needs_modrm = 1'b1;
				is_mem = 1'b1;
				bad_form = (modrm[7:6] == 2'h3);
			end
			`AM_RONLY:
			begin
				needs_modrm = 1'b1;
				reg_num = modrm[2:0];
				reg_file = op32 ? `RF_GEN32 : `RF_GEN16;
			end
			`AM_RM:
			begin
				needs_modrm = 1'b1;
				reg_num = modrm[2:0];
				is_mem = (modrm[7:6] != 2'h3);
				if (modrm[7:6] == 2'h3)
					reg_file = (size_bytes == 4'h1) ? `RF_GEN8 :
						(size_bytes == 4'h4) ? `RF_GEN32 : `RF_GEN16;
			end
			`AM_IMM:
				imm_bytes = (size_bytes > 4'h4) ? 3'h4 : size_bytes[2:0];
			default:
				reg_num = 3'h0;
		endcase
	end
endmodule // operand_spec_decode
`default_nettype wire

/* rtl/opcode_operand_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decoder_defs.vh"
module opcode_operand_decoder
(
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// From fetch unit
	input wire byte_valid,
	input wire [7:0] byte_data,
	input wire op32,
	input wire addr32,
	output wire byte_ready,
	// To execution pipeline
	output reg dec_valid,
	output reg two_byte,
	output reg [7:0] opcode,
	output reg [7:0] modrm,
	output reg [3:0] method1,
	output reg [2:0] type1,
	output reg [3:0] method2,
	output reg [2:0] type2,
	output reg [3:0] size1,
	output reg [2:0] reg_file1,
	output reg [2:0] reg_num1,
	output reg mem1,
	output reg [2:0] seg1,
	output reg [3:0] size2,
	output reg [2:0] reg_file2,
	output reg [2:0] reg_num2,
	output reg mem2,
	output reg [2:0] seg2,
	output reg [2:0] imm_bytes,
	output reg rel_signed,
	output reg size_dependent_register,
	// To exception logic
	output reg invalid_opcode
);
	localparam S_FIRST = 3'b001;
	localparam S_ESC = 3'b010;
	localparam S_MODRM = 3'b100;

	reg [2:0] state;
	reg [7:0] op_hold;
	reg esc_hold;
	reg [3:0] tm1, tm2;
	reg [2:0] tt1, tt2;
	reg tbl_undef;
	reg cur_esc;
	reg [7:0] cur_op;
	wire [3:0] row;
	wire [3:0] col;
	wire [7:0] cur_modrm;
	wire nm1, nm2, bf1, bf2, rs1, rs2;
	wire [3:0] sz1, sz2;
	wire [2:0] rf1, rf2, rn1, rn2, sg1, sg2, ib1, ib2;
	wire im1, im2;

	assign byte_ready = 1'b1;
	assign cur_modrm = (state == S_MODRM) ? byte_data : 8'h00;

	always @*
	begin
		cur_esc = (state == S_ESC);
		cur_op = (state == S_MODRM) ? op_hold : byte_data;
		if (state == S_MODRM)
			cur_esc = esc_hold;
	end

	assign row = cur_op[7:4];
	assign col = cur_op[3:0];

	// Operand descriptor table; only a representative set of cells is populated
	always @*
	begin
		tm1 = `AM_NONE;
		tt1 = `OT_NONE;
		tm2 = `AM_NONE;
		tt2 = `OT_NONE;
		tbl_undef = 1'b0;
		if (!cur_esc)
		begin
			case (row)
				4'h0, 4'h1, 4'h2, 4'h3:
				begin
					if (col[2:0] <= 3'h3)
					begin
						tm1 = col[1] ? `AM_GREG : `AM_RM;
						tm2 = col[1] ? `AM_RM : `AM_GREG;
						tt1 = col[0] ? `OT_V : `OT_B;
						tt2 = col[0] ? `OT_V : `OT_B;
					end
					else if (col[2:0] <= 3'h5)
					begin
						tm2 = `AM_IMM;
						tt2 = col[0] ? `OT_V : `OT_B;
					end
				end
				4'h6:
					if (col == 4'h2)
					begin
						tm1 = `AM_GREG;
						tt1 = `OT_V;
						tm2 = `AM_MEM;
						tt2 = `OT_A;
					end
				4'h7:
				begin
					tm1 = `AM_REL;
					tt1 = `OT_B;
				end
				4'hE:
				begin
					if (col == 4'hA)
					begin
						tm1 = `AM_DIRECT;
						tt1 = `OT_P;
					end
					else if (col[3:1] == 3'h4)
					begin
						tm1 = `AM_REL;
						tt1 = `OT_V;
					end
					else if (col[3:2] == 2'h0 || col == 4'hB)
					begin
						tm1 = `AM_REL;
						tt1 = `OT_B;
					end
				end
				4'h8:
				begin
					if (col == 4'hC || col == 4'hE)
					begin
						tm1 = col[1] ? `AM_SEG : `AM_RM;
						tm2 = col[1] ? `AM_RM : `AM_SEG;
						tt1 = `OT_W;
						tt2 = `OT_W;
					end
					else if (col == 4'hD)
					begin
						tm1 = `AM_GREG;
						tt1 = `OT_V;
						tm2 = `AM_MEM;
					end
					else if (col[3:2] == 2'h2)
					begin
						tm1 = col[1] ? `AM_GREG : `AM_RM;
						tm2 = col[1] ? `AM_RM : `AM_GREG;
						tt1 = col[0] ? `OT_V : `OT_B;
						tt2 = col[0] ? `OT_V : `OT_B;
					end
				end
				4'h9:
					if (col == 4'hA)
					begin
						tm1 = `AM_DIRECT;
						tt1 = `OT_P;
					end
				4'hA:
				begin
					if (col[3:2] == 2'h0)
					begin
						tm1 = col[1] ? `AM_MOFFS : `AM_NONE;
						tm2 = col[1] ? `AM_NONE : `AM_MOFFS;
						tt1 = col[0] ? `OT_V : `OT_B;
						tt2 = col[0] ? `OT_V : `OT_B;
					end
					else if (col[3:2] == 2'h1)
					begin
						tm1 = `AM_SRCSTR;
						tm2 = `AM_DSTSTR;
						tt1 = col[0] ? `OT_V : `OT_B;
						tt2 = col[0] ? `OT_V : `OT_B;
					end
				end
				4'hC:
					if (col == 4'h4 || col == 4'h5)
					begin
						tm1 = `AM_GREG;
						tt1 = `OT_V;
						tm2 = `AM_MEM;
						tt2 = `OT_P;
					end
				4'hF:
					tbl_undef = (col == 4'h1);
				default:
					tbl_undef = 1'b0;
			endcase
		end
		else
		begin
			case (row)
				4'h0:
					tbl_undef = (col[3:2] == 2'h1 && col != 4'h6) || col[3];
				4'h2:
					if (col[3] || col == 4'h5 || col == 4'h7)
						tbl_undef = 1'b1;
					else
					begin
						tm1 = col[1] ? `AM_RONLY : (col[2] ? `AM_TEST :
							(col[0] ? `AM_DEBUG : `AM_CTRL));
						tm2 = col[1] ? (col[2] ? `AM_TEST :
							(col[0] ? `AM_DEBUG : `AM_CTRL)) : `AM_RONLY;
						tt1 = `OT_D;
						tt2 = `OT_D;
					end
				4'h8:
				begin
					tm1 = `AM_REL;
					tt1 = `OT_V;
				end
				4'h9:
				begin
					tm1 = `AM_RM;
					tt1 = `OT_B;
				end
				4'hA, 4'hB, 4'hC:
					tbl_undef = 1'b0;
				default:
					tbl_undef = 1'b1;
			endcase
		end
	end

	operand_spec_decode u_op1
	(
		.method(tm1),
		.otype(tt1),
		.op32(op32),
		.addr32(addr32),
		.modrm(cur_modrm),
		.needs_modrm(nm1),
		.size_bytes(sz1),
		.reg_file(rf1),
		.reg_num(rn1),
		.is_mem(im1),
		.seg_sel(sg1),
		.imm_bytes(ib1),
		.rel_signed(rs1),
		.bad_form(bf1)
	);

	operand_spec_decode u_op2
	(
		.method(tm2),
		.otype(tt2),
		.op32(op32),
		.addr32(addr32),
		.modrm(cur_modrm),
		.needs_modrm(nm2),
		.size_bytes(sz2),
		.reg_file(rf2),
		.reg_num(rn2),
		.is_mem(im2),
		.seg_sel(sg2),
		.imm_bytes(ib2),
		.rel_signed(rs2),
		.bad_form(bf2)
	);

	// Register-or-memory operands wait for the specifier byte before issue
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= S_FIRST;
			op_hold <= 8'h00;
			esc_hold <= 1'b0;
			dec_valid <= 1'b0;
			two_byte <= 1'b0;
			opcode <= 8'h00;
			modrm <= 8'h00;
			method1 <= 4'h0;
			type1 <= 3'h0;
			method2 <= 4'h0;
			type2 <= 3'h0;
			size1 <= 4'h0;
			reg_file1 <= 3'h0;
			reg_num1 <= 3'h0;
			mem1 <= 1'b0;
			seg1 <= 3'h0;
			size2 <= 4'h0;
			reg_file2 <= 3'h0;
			reg_num2 <= 3'h0;
			mem2 <= 1'b0;
			seg2 <= 3'h0;
			imm_bytes <= 3'h0;
			rel_signed <= 1'b0;
			size_dependent_register <= 1'b0;
			invalid_opcode <= 1'b0;
		end
		else
		begin
			dec_valid <= 1'b0;
			invalid_opcode <= 1'b0;
			if (byte_valid)
			begin
				case (state)
					S_FIRST, S_ESC:
					begin
						if (state == S_FIRST && byte_data == `ESCAPE_BYTE)
							state <= S_ESC;
						else if (tbl_undef)
						begin
							invalid_opcode <= 1'b1;
							state <= S_FIRST;
						end
						else if (nm1 || nm2)
						begin
							op_hold <= byte_data;
							esc_hold <= cur_esc;
							state <= S_MODRM;
						end
						else
						begin
							dec_valid <= 1'b1;
							state <= S_FIRST;
						end
					end
					S_MODRM:
					begin
						state <= S_FIRST;
						invalid_opcode <= bf1 | bf2;
						dec_valid <= ~(bf1 | bf2);
					end
					default:
						state <= S_FIRST;
				endcase
				if ((state != S_MODRM && !(state == S_FIRST && byte_data == `ESCAPE_BYTE)
					&& !tbl_undef) || state == S_MODRM)
				begin
					two_byte <= cur_esc;
					opcode <= cur_op;
					modrm <= cur_modrm;
					method1 <= tm1;
					type1 <= tt1;
					method2 <= tm2;
					type2 <= tt2;
					size1 <= sz1;
					reg_file1 <= rf1;
					reg_num1 <= rn1;
					mem1 <= im1;
					seg1 <= sg1;
					size2 <= sz2;
					reg_file2 <= rf2;
					reg_num2 <= rn2;
					mem2 <= im2;
					seg2 <= sg2;
					imm_bytes <= ib1 + ib2;
					rel_signed <= rs1 | rs2;
					size_dependent_register <= (tt1 == `OT_V) | (tt2 == `OT_V);
				end
			end
		end
	end
endmodule // opcode_operand_decoder
`default_nettype wire

/* test/decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decoder_defs.vh"
module decoder_checker
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Fetch side
	input wire logic [7:0] byte_data,
	input wire logic op32,
	input wire logic addr32,
	// Decode side
	input wire logic dec_valid,
	input wire logic invalid_opcode,
	input wire logic two_byte,
	input wire logic [7:0] opcode,
	input wire logic [7:0] modrm,
	input wire logic [3:0] method1,
	input wire logic [3:0] method2,
	input wire logic [2:0] type1,
	input wire logic [3:0] size1,
	input wire logic [2:0] reg_file1,
	input wire logic [2:0] reg_num1,
	input wire logic mem1,
	input wire logic [2:0] seg1,
	input wire logic [2:0] imm_bytes,
	input wire logic rel_signed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	function automatic logic [3:0] exp_size(input logic [2:0] t, input logic w);
		case (t)
			`OT_B: return 4'h1;
			`OT_W: return 4'h2;
			`OT_D: return 4'h4;
			`OT_V: return w ? 4'h4 : 4'h2;
			`OT_P: return w ? 4'h6 : 4'h4;
			`OT_S: return 4'h6;
			default: return w ? 4'h8 : 4'h4;
		endcase
	endfunction
	function automatic logic reg_ok(input logic [3:0] m, input logic [2:0] f, n,
		input logic mm, input logic [7:0] b);
		case (m)
			`AM_CTRL: return f == `RF_CTRL && n == b[5:3];
			`AM_DEBUG: return f == `RF_DEBUG && n == b[5:3];
			`AM_TEST: return f == `RF_TEST && n == b[5:3];
			`AM_SEG: return f == `RF_SEG && n == b[5:3];
			`AM_RONLY: return !mm && n == b[2:0];
			`AM_MEM: return mm;
			`AM_RM: return mm == (b[7:6] != 2'h3) && (mm || n == b[2:0]);
			default: return 1'b1;
		endcase
	endfunction
	answer_excl_a: assert property (!(dec_valid && invalid_opcode))
		else $error("decode and invalid together");
	escape_table_a: assert property (dec_valid && two_byte |->
		$past(byte_data, 2) == `ESCAPE_BYTE || $past(byte_data, 3) == `ESCAPE_BYTE)
		else $error("two-byte decode without escape");
	opcode_byte_a: assert property (dec_valid && !two_byte |->
		opcode == $past(byte_data) || opcode == $past(byte_data, 2))
		else $error("opcode not a fetched byte");
	reg_field_a: assert property (dec_valid |->
		reg_ok(method1, reg_file1, reg_num1, mem1, modrm))
		else $error("register field misdecoded");
	op_size_a: assert property (dec_valid && method1 != `AM_NONE && type1 != `OT_NONE |->
		size1 == exp_size(type1, $past(op32)))
		else $error("operand size wrong");
	gen_width_a: assert property (dec_valid && method1 == `AM_GREG && type1 == `OT_V |->
		reg_file1 == ($past(op32) ? `RF_GEN32 : `RF_GEN16))
		else $error("register width wrong");
	moffs_len_a: assert property (dec_valid && (method1 == `AM_MOFFS || method2 == `AM_MOFFS) |->
		imm_bytes == ($past(addr32) ? 3'h4 : 3'h2) && modrm == 8'h00)
		else $error("offset length wrong");
	direct_len_a: assert property (dec_valid && method1 == `AM_DIRECT |->
		imm_bytes == ($past(op32) ? 3'h6 : 3'h4) && opcode == $past(byte_data))
		else $error("direct address length wrong");
	string_ptr_a: assert property (dec_valid && method1 inside {`AM_SRCSTR, `AM_DSTSTR} |->
		{seg1, reg_num1} == (method1 == `AM_SRCSTR ? {`SEG_DS, `REG_SI} : {`SEG_ES, `REG_DI}))
		else $error("string pointer wrong");
	rel_disp_a: assert property (dec_valid && method1 == `AM_REL |->
		rel_signed && imm_bytes != 3'h0)
		else $error("relative displacement missing");
	cover property (dec_valid && two_byte);
	cover property (invalid_opcode);
	cover property (dec_valid && method1 == `AM_SRCSTR);
endmodule // decoder_checker
bind opcode_operand_decoder decoder_checker props (.*);
`default_nettype wire

/* test/fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
	// Clock
	input wire logic core_clk,
	// Byte stream to the decoder
	output logic byte_valid,
	output logic [7:0] byte_data
);
	initial
	begin
		byte_valid = 1'b0;
		byte_data = 8'h5A;
	end
	task automatic put(input logic [7:0] b);
		@(negedge core_clk);
		byte_valid = 1'b1;
		byte_data = b;
	endtask
	// Released bus flips, so a stale byte is never mistaken for data
	task automatic idle();
		@(negedge core_clk);
		byte_valid = 1'b0;
		byte_data = ~byte_data;
	endtask
endmodule // fetch_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decoder_defs.vh"
module tb_top;
	logic core_clk, nrst, op32, addr32;
	wire logic byte_valid, byte_ready, dec_valid, two_byte, mem1, mem2, rel_signed;
	wire logic size_dependent_register, invalid_opcode;
	wire logic [7:0] byte_data, opcode, modrm;
	wire logic [3:0] method1, method2, size1, size2;
	wire logic [2:0] type1, type2, reg_file1, reg_file2, reg_num1, reg_num2, seg1, seg2, imm_bytes;
	int fail_count, compares, cyc;
	logic [31:0] rs, r;
	logic [7:0] m;
	logic [2:0] c;
	opcode_operand_decoder uut (.*);
	fetch_model fm (.*);
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [3:0] wsz(input logic w, input logic [3:0] lo, hi);
		return w ? hi : lo;
	endfunction
	function automatic logic cr(input logic [3:0] em, input logic [2:0] ef);
		return (method1 == em && reg_file1 == ef && reg_num1 == m[5:3]) ||
			(method2 == em && reg_file2 == ef && reg_num2 == m[5:3]);
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Answer is due exactly one cycle after the last byte
	task automatic ins(input logic [23:0] b, input int n, input logic bad);
		for (int i = 0; i < n; i++)
			fm.put(b[23 - 8 * i -: 8]);
		fm.idle();
		chk("answer", {14'h0, bad, !bad}, {14'h0, invalid_opcode, dec_valid});
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		rs = 32'h6F42;
		nrst = 0;
		op32 = 0;
		addr32 = 0;
		repeat (4) @(negedge core_clk);
		nrst = 1;
		chk("reset", 16'h0080, {8'h0, byte_ready, dec_valid, invalid_opcode, two_byte, mem1, imm_bytes});
		repeat (16)
		begin
			r = rnd();
			op32 = r[8];
			ins({6'h0, r[9], 1'b1, r[7:0], 8'h00}, 2, 0);
			chk("greg", {10'h0, op32 ? `RF_GEN32 : `RF_GEN16, r[5:3]},
				{10'h0, r[9] ? {reg_file1, reg_num1} : {reg_file2, reg_num2}});
			chk("emem", {14'h0, r[7:6] != 2'h3, 1'b1},
				{14'h0, r[9] ? mem2 : mem1, size_dependent_register});
		end
		$display("regmem done");
		for (int k = 0; k < 12; k++)
		begin
			m = {2'h3, 3'(k / 2), 3'h1};
			ins({k[0] ? 8'h8E : 8'h8C, m, 8'h00}, 2, 0);
			chk("sreg", {5'h0, `AM_SEG, `RF_SEG, m[5:3]},
				{5'h0, k[0] ? {method1, reg_file1, reg_num1} : {method2, reg_file2, reg_num2}});
		end
		$display("segment done");
		for (int i = 0; i < 6; i++)
		begin
			r = rnd();
			m = {2'h3, r[5:0]};
			c = (i == 5) ? 3'h6 : 3'(i);
			ins({8'h0F, 5'h04, c, m}, 3, 0);
			chk("esc", {8'h01, 5'h04, c}, {7'h0, two_byte, opcode});
			chk("creg", 16'h1, {15'h0, cr(c[2] ? `AM_TEST : c[0] ? `AM_DEBUG : `AM_CTRL,
				c[2] ? `RF_TEST : c[0] ? `RF_DEBUG : `RF_CTRL)});
		end
		fm.put(8'h0F);
		fm.idle();
		nrst = 0;
		@(negedge core_clk);
		nrst = 1;
		ins({8'h90, 16'h0}, 1, 0);
		chk("rst esc", 16'h0090, {7'h0, two_byte, opcode});
		$display("escape done");
		for (int i = 0; i < 6; i++)
		begin
			r = rnd();
			{op32, addr32} = r[1:0];
			ins({i < 4 ? 8'hA0 + 8'(i) : 8'hEA, 16'h0}, 1, 0);
			chk("len", {12'h0, i < 4 ? wsz(addr32, 4'h2, 4'h4) : wsz(op32, 4'h4, 4'h6)},
				{13'h0, imm_bytes});
			chk("nospec", 16'h0, {8'h0, modrm});
		end
		addr32 = 0;
		$display("offset done");
		for (int i = 0; i < 4; i++)
		begin
			ins({8'hA4 + 8'(i), 16'h0}, 1, 0);
			chk("str", {2'h0, `SEG_DS, `REG_SI, 1'b1, `SEG_ES, `REG_DI, 1'b1},
				{2'h0, seg1, reg_num1, mem1, seg2, reg_num2, mem2});
		end
		for (int i = 0; i < 20; i++)
		begin
			ins({i < 16 ? 8'h70 + 8'(i) : 8'hD0 + 8'(i), 16'h0}, 1, 0);
			chk("rel", {8'h0, `AM_REL, 1'b1, 3'h1}, {8'h0, method1, rel_signed, imm_bytes});
		end
		$display("string rel done");
		for (int i = 0; i < 4; i++)
		begin
			op32 = i[1];
			ins({8'h04 + 8'(i % 2), 16'h0}, 1, 0);
			chk("imm", {5'h0, `AM_IMM, i[0] ? `OT_V : `OT_B, i[0] ? wsz(op32, 4'h2, 4'h4) : 4'h1},
				{5'h0, method2, type2, 1'b0, imm_bytes});
		end
		for (int i = 0; i < 4; i++)
		begin
			r = rnd();
			op32 = i[0];
			ins({i[1] ? 8'h62 : 8'hC4, 1'b0, r[6:0], 8'h0}, 2, 0);
			chk("mptr", {11'h1, i[1] ? wsz(op32, 4'h4, 4'h8) : wsz(op32, 4'h4, 4'h6)},
				{11'h0, mem2, size2});
		end
		ins({8'hC4, 8'hC0, 8'h0}, 2, 1);
		ins({8'hF1, 16'h0}, 1, 1);
		ins({8'h0F, 8'h30, 8'h0}, 2, 1);
		ins({8'h0F, 8'h25, 8'h0}, 2, 1);
		ins({8'h90, 16'h0}, 1, 0);
		$display("imm invalid done");
		results();
	end
endmodule // tb_top
`default_nettype wire
